// ---- common/eipc_pkg.sv ----
// Register map, field positions and reset values of the external interrupt pin control.
`default_nettype none
package eipc_pkg;
   localparam int          NUM_PINS       = 3;
   localparam int          APB_ADDR_W     = 18;
   localparam int          REG_W          = 16;
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] IDX_CTL1       = 16'h7070;
   localparam logic [15:0] IDX_CTL2       = 16'h7078;
   localparam logic [15:0] IDX_CTL3       = 16'h707a;
   localparam logic [15:0] IDX_EVT_STATUS = 16'h7080;
   localparam logic [15:0] IDX_EVT_MASK   = 16'h7081;
   localparam logic [15:0] IDX_CONFIG     = 16'h7082;
   // Control register fields.
   localparam int          BIT_FLAG       = 15;
   localparam int          BIT_PIN_LEVEL  = 6;
   localparam int          BIT_DIR        = 4;
   localparam int          BIT_OUT        = 3;
   localparam int          BIT_POLARITY   = 2;
   localparam int          BIT_PRIORITY   = 1;
   localparam int          BIT_ENABLE     = 0;
   // Stored control bits: enable, priority, polarity, output value, direction.
   localparam int          CTL_W          = 5;
   localparam logic [4:0]  CTL_RESET      = 5'h00;
   localparam logic [4:0]  CTL_MASK_PIN1  = 5'h07;
   localparam logic [4:0]  CTL_MASK_PIN23 = 5'h1f;
   // Configuration register fields.
   localparam int          BIT_NMI_SELECT = 0;
   localparam logic [2:0]  EVT_RESET      = 3'h0;
   localparam logic        NMI_SEL_RESET  = 1'b0;
   // Cycles after reset before edge detection trusts the synchronised level.
   localparam logic [1:0]  SETTLE_CYCLES  = 2'h3;

   function automatic logic [APB_ADDR_W-1:0] byte_addr(input logic [15:0] idx);
      byte_addr = {idx, 2'b00};
   endfunction : byte_addr
endpackage : eipc_pkg
`default_nettype wire

// ---- rtl/eipc_sync.sv ----
// Two flip-flop level synchroniser for the interrupt pins.
`default_nettype none
module eipc_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule : eipc_sync
`default_nettype wire

// ---- rtl/eipc_pin.sv ----
// One interrupt pin: edge detection, transition flag and pending request.
`default_nettype none
module eipc_pin
   import eipc_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic level,
   input  wire logic polarity,
   input  wire logic req_en,
   input  wire logic flag_clr,
   input  wire logic req_ack,
   output logic      edge_pulse,
   output logic      flag,
   output logic      pending
);
   logic       prev_ff;
   logic       flag_ff;
   logic       pend_ff;
   logic [1:0] settle_ff;
   logic       settled;

   // The synchroniser shows zero until the real level arrives; that step must not look like an edge.
   assign settled = (settle_ff == SETTLE_CYCLES);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         settle_ff <= 2'h0;
      end else if (!settled) begin
         settle_ff <= settle_ff + 2'h1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= level;
      end
   end

   assign edge_pulse = settled && (polarity ? (level && !prev_ff) : (!level && prev_ff));

   // A new edge wins over a clear in the same cycle.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flag_ff <= 1'b0;
      end else if (edge_pulse) begin
         flag_ff <= 1'b1;
      end else if (flag_clr) begin
         flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pend_ff <= 1'b0;
      end else if (edge_pulse && req_en) begin
         pend_ff <= 1'b1;
      end else if (flag_clr || req_ack) begin
         pend_ff <= 1'b0;
      end
   end

   assign flag    = flag_ff;
   assign pending = pend_ff;
endmodule : eipc_pin
`default_nettype wire

// ---- rtl/eipc_top.sv ----
// External interrupt pin control with its APB register file.
// How it works
// - Selected edge sets the pin's transition flag even with the interrupt disabled.
// - Flag clears only by software clear-write or reset; writes never set it.
// - Enabled pin raises one request per selected edge, flag state notwithstanding.
// - Clearing the flag also withdraws that pin's pending request.
// - Bit 6 reads the live pin level; writes to it are ignored.
// - Bit 2 selects edge: 0 falling, 1 rising; resets to 0.
// - Bit 1 selects priority: 0 high, 1 low.
// - Bit 0 enables the maskable request; 0 leaves pin digital I/O, bit 4 choosing direction on pins two and three.
// - Pin one under nonmaskable selection ignores its priority and enable bits.
// - Pins two and three: bit 4 sets direction when interrupts disabled.
// - Pins two and three: bit 3 drives the output level.
// - Reserved bits ignore writes; they read as zero here.
// - Control bits and flag reset to zero; pin level follows the pin.
//
// The APB register port was chosen for this implementation.
`default_nettype none
module eipc_top
   import eipc_pkg::*;
(
   input  wire logic                            clock,
   input  wire logic                            rst,
   // APB slave.
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [eipc_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                     pwdata,
   input  wire logic [3:0]                      pstrb,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   // Pins: index 0 is pin one (input only), 1 and 2 are pins two and three.
   input  wire logic [eipc_pkg::NUM_PINS-1:0]   pin_in,
   output logic      [eipc_pkg::NUM_PINS-1:0]   pin_out,
   output logic      [eipc_pkg::NUM_PINS-1:0]   pin_oe,
   // CPU interrupt logic.
   output logic      [eipc_pkg::NUM_PINS-1:0]   int_req,
   output logic      [eipc_pkg::NUM_PINS-1:0]   int_req_low_pri,
   input  wire logic [eipc_pkg::NUM_PINS-1:0]   int_ack,
   output logic                                 nmi_req,
   input  wire logic                            nmi_ack,
   output logic                                 irq
);
   import eipc_pkg::*;

   logic [CTL_W-1:0]    ctl_ff [NUM_PINS];
   logic [NUM_PINS-1:0] evt_status_ff;
   logic [NUM_PINS-1:0] evt_mask_ff;
   logic                nmi_sel_ff;
   logic [31:0]         prdata_ff;

   logic [NUM_PINS-1:0] pin_level;
   logic [NUM_PINS-1:0] edge_pulse;
   logic [NUM_PINS-1:0] flag;
   logic [NUM_PINS-1:0] pending;
   logic [NUM_PINS-1:0] req_en;
   logic [NUM_PINS-1:0] req_ack;
   logic [NUM_PINS-1:0] flag_clr;
   logic [NUM_PINS-1:0] ctl_hit;
   logic [NUM_PINS-1:0] nxt_evt_status;

   logic                setup_phase;
   logic                wr_access;
   logic                hit_status;
   logic                hit_mask;
   logic                hit_config;
   logic                mapped;
   logic [REG_W-1:0]    wr_data16;
   logic [REG_W-1:0]    wr_lanes16;
   logic [31:0]         nxt_prdata;
   logic [NUM_PINS-1:0] wr_ctl_lo;
   logic [NUM_PINS-1:0] wr_ctl_hi;
   logic                wr_status;
   logic                wr_mask;
   logic                wr_config;

   // Index of the control register of each pin.
   function automatic logic [15:0] ctl_index(input int pin);
      if (pin == 0) begin
         ctl_index = IDX_CTL1;
      end else if (pin == 1) begin
         ctl_index = IDX_CTL2;
      end else begin
         ctl_index = IDX_CTL3;
      end
   endfunction : ctl_index

   // Which stored control bits a pin really has.
   function automatic logic [CTL_W-1:0] ctl_writable(input int pin);
      ctl_writable = (pin == 0) ? CTL_MASK_PIN1 : CTL_MASK_PIN23;
   endfunction : ctl_writable

   // Bits a control write may store; reserved and absent bits never reach the flops.
   function automatic logic [CTL_W-1:0] ctl_store(input int pin, input logic [REG_W-1:0] d);
      ctl_store = d[CTL_W-1:0] & ctl_writable(pin);
   endfunction : ctl_store

   // Read image of a control register; reserved bits read as zero.
   function automatic logic [REG_W-1:0] ctl_image(input logic [CTL_W-1:0] ctl, input logic flg,
                                                  input logic lvl);
      logic [REG_W-1:0] img;
      img                = '0;
      img[BIT_FLAG]      = flg;
      img[BIT_PIN_LEVEL] = lvl;
      img[BIT_DIR]       = ctl[4];
      img[BIT_OUT]       = ctl[3];
      img[BIT_POLARITY]  = ctl[2];
      img[BIT_PRIORITY]  = ctl[1];
      img[BIT_ENABLE]    = ctl[0];
      ctl_image          = img;
   endfunction : ctl_image

   // ------------------------------------------------------------ pin front end
   eipc_sync #(
      .WIDTH    (NUM_PINS)
   ) u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in (pin_in),
      .sync_out (pin_level)
   );

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         eipc_pin u_pin (
            .clock      (clock),
            .rst        (rst),
            .level      (pin_level[g]),
            .polarity   (ctl_ff[g][BIT_POLARITY]),
            .req_en     (req_en[g]),
            .flag_clr   (flag_clr[g]),
            .req_ack    (req_ack[g]),
            .edge_pulse (edge_pulse[g]),
            .flag       (flag[g]),
            .pending    (pending[g])
         );
      end
   endgenerate

   // Pin one can be steered to the nonmaskable request; its enable and priority then do nothing.
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         req_en[i]  = ctl_ff[i][BIT_ENABLE];
         req_ack[i] = int_ack[i];
      end
      if (nmi_sel_ff) begin
         req_en[0]  = 1'b1;
         req_ack[0] = nmi_ack;
      end
   end

   // A pending request survives a cleared enable bit and shows again once the bit is set.
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         int_req[i]         = pending[i] && ctl_ff[i][BIT_ENABLE];
         int_req_low_pri[i] = ctl_ff[i][BIT_PRIORITY];
      end
      nmi_req = pending[0] && nmi_sel_ff;
      if (nmi_sel_ff) begin
         int_req[0]         = 1'b0;
         int_req_low_pri[0] = 1'b0;
      end
   end

   // Digital output only while the interrupt is disabled; pin one never drives.
   always_comb begin
      pin_out = '0;
      pin_oe  = '0;
      for (int i = 1; i < NUM_PINS; i++) begin
         pin_out[i] = ctl_ff[i][BIT_OUT];
         pin_oe[i]  = ctl_ff[i][BIT_DIR] && !ctl_ff[i][BIT_ENABLE];
      end
   end

   // ------------------------------------------------------------ APB decode
   assign setup_phase = psel && !penable;
   assign wr_access   = psel && penable && pwrite;
   assign wr_data16   = pwdata[REG_W-1:0];
   assign wr_lanes16  = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // Only the exact word address hits; the other byte addresses of a word are unmapped.
   always_comb begin
      hit_status = 1'b0;
      hit_mask   = 1'b0;
      hit_config = 1'b0;
      ctl_hit    = '0;
      if (paddr == byte_addr(IDX_EVT_STATUS)) begin
         hit_status = 1'b1;
      end else if (paddr == byte_addr(IDX_EVT_MASK)) begin
         hit_mask = 1'b1;
      end else if (paddr == byte_addr(IDX_CONFIG)) begin
         hit_config = 1'b1;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (paddr == byte_addr(ctl_index(i))) begin
               ctl_hit[i] = 1'b1;
            end
         end
      end
   end

   assign mapped  = hit_status || hit_mask || hit_config || (|ctl_hit);
   // Every access finishes in one access cycle; read data was captured in the setup cycle.
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_ff;

   // Lane-qualified write strobes: the flag sits in the upper byte, the stored control bits in the lower one.
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         wr_ctl_lo[i] = wr_access && ctl_hit[i] && pstrb[0];
         wr_ctl_hi[i] = wr_access && ctl_hit[i] && pstrb[1];
      end
      wr_status = wr_access && hit_status && pstrb[0];
      wr_mask   = wr_access && hit_mask && pstrb[0];
      wr_config = wr_access && hit_config && wr_lanes16[BIT_NMI_SELECT];
   end

   // The level bit shows the synchronised pin, two clocks behind the pin itself.
   always_comb begin
      nxt_prdata = '0;
      if (hit_status) begin
         nxt_prdata[NUM_PINS-1:0] = evt_status_ff;
      end else if (hit_mask) begin
         nxt_prdata[NUM_PINS-1:0] = evt_mask_ff;
      end else if (hit_config) begin
         nxt_prdata[BIT_NMI_SELECT] = nmi_sel_ff;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (ctl_hit[i]) begin
               nxt_prdata[REG_W-1:0] = ctl_image(ctl_ff[i], flag[i], pin_level[i]);
            end
         end
      end
   end

   // Capturing in the setup cycle keeps prdata steady for the whole access phase.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // ------------------------------------------------------------ registers
   // Writing a one to the flag bit clears it; a zero leaves it alone.
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         flag_clr[i] = wr_ctl_hi[i] && wr_data16[BIT_FLAG];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            ctl_ff[i] <= CTL_RESET;
         end
      end else if (wr_access) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (wr_ctl_lo[i]) begin
               ctl_ff[i] <= ctl_store(i, wr_data16);
            end
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         nmi_sel_ff <= NMI_SEL_RESET;
      end else if (wr_config) begin
         nmi_sel_ff <= wr_data16[BIT_NMI_SELECT];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         evt_mask_ff <= EVT_RESET;
      end else if (wr_mask) begin
         evt_mask_ff <= wr_data16[NUM_PINS-1:0];
      end
   end

   // Sticky edge events; a new edge beats a write-one-to-clear in the same cycle.
   always_comb begin
      nxt_evt_status = evt_status_ff;
      if (wr_status) begin
         nxt_evt_status = evt_status_ff & ~wr_data16[NUM_PINS-1:0];
      end
      nxt_evt_status = nxt_evt_status | edge_pulse;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         evt_status_ff <= EVT_RESET;
      end else begin
         evt_status_ff <= nxt_evt_status;
      end
   end

   // The summary interrupt is a plain level; software clears its cause in the event register.
   assign irq = |(evt_status_ff & evt_mask_ff);
endmodule : eipc_top
`default_nettype wire

// ---- testbench/eipc_top_asserts.sv ----
// Port assertions for the external interrupt pin control.
`default_nettype none
module eipc_top_asserts (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [2:0]  pin_in,
   input wire logic [2:0]  pin_out,
   input wire logic [2:0]  pin_oe,
   input wire logic [2:0]  int_req,
   input wire logic [2:0]  int_req_low_pri,
   input wire logic [2:0]  int_ack,
   input wire logic        nmi_req,
   input wire logic        nmi_ack,
   input wire logic        irq
);
   logic [14:0] hist_ff;
   logic        wr_ff;
   logic        quiet;
   // Five equal samples mean no edge can still be inside the synchroniser.
   assign quiet = (hist_ff == {5{pin_in}});
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hist_ff <= 15'h0000;
         wr_ff   <= 1'b0;
      end else begin
         hist_ff <= {hist_ff[11:0], pin_in};
         wr_ff   <= psel & penable & pwrite;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access");
   a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_reserved_zero: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0 && prdata[14:7] == 8'h0)
      else $error("reserved bits not zero");
   a_pin_one_input: assert property (pin_oe[0] == 1'b0 && pin_out[0] == 1'b0)
      else $error("pin one driven");
   a_oe_blocks_req: assert property ((pin_oe & int_req) == 3'h0)
      else $error("request on a driven pin");
   a_nmi_exclusive: assert property (nmi_req |-> !int_req[0] && !int_req_low_pri[0])
      else $error("pin one maskable under nmi");
   a_edge_needed: assert property (quiet && !wr_ff |-> (int_req & ~$past(int_req)) == 3'h0 && !$rose(nmi_req) && !$rose(irq))
      else $error("request without edge");
   a_req_holds: assert property (!wr_ff |-> (~int_req & $past(int_req) & ~$past(int_ack)) == 3'h0)
      else $error("request lost");
   a_ack_clears: assert property (quiet && (int_ack & int_req) != 3'h0 |=> (int_req & $past(int_ack)) == 3'h0)
      else $error("ack did not clear");
   c_nmi_taken: cover property (nmi_req && nmi_ack);
   c_req_taken: cover property ((int_ack & int_req) != 3'h0);
   c_refused: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule : eipc_top_asserts
bind eipc_top eipc_top_asserts u_eipc_top_asserts (
   .clock, .rst, .psel, .penable, .pwrite, .prdata, .pslverr, .pin_in, .pin_out, .pin_oe,
   .int_req, .int_req_low_pri, .int_ack, .nmi_req, .nmi_ack, .irq
);
`default_nettype wire

// ---- testbench/eipc_pins_model.sv ----
// Model of the pins and of the CPU interrupt logic that takes requests.
`default_nettype none
module eipc_pins_model (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [2:0] lvl,
   input  wire logic       ack_en,
   input  wire logic [3:0] ack_dly,
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   input  wire logic [2:0] int_req,
   input  wire logic       nmi_req,
   output logic      [2:0] pin_in,
   output logic      [2:0] int_ack,
   output logic            nmi_ack,
   output logic      [7:0] acks
);
   logic [3:0] wait_ff;
   // A pin the device drives follows its driver; otherwise the outside level wins.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wait_ff <= 4'h0;
         int_ack <= 3'h0;
         nmi_ack <= 1'b0;
         acks    <= 8'h00;
      end else begin
         int_ack <= 3'h0;
         nmi_ack <= 1'b0;
         if (!ack_en || !(|int_req || nmi_req) || |int_ack || nmi_ack) begin
            wait_ff <= 4'h0;
         end else if (wait_ff != ack_dly) begin
            wait_ff <= wait_ff + 4'h1;
         end else begin
            // The lowest maskable request is taken first; the nonmaskable one waits until no maskable request is left.
            int_ack <= int_req & (~int_req + 3'h1);
            nmi_ack <= nmi_req & ~|int_req;
            acks    <= acks + 8'h01;
         end
      end
   end
endmodule : eipc_pins_model
`default_nettype wire

// ---- testbench/eipc_top_bench.sv ----
// Self-checking bench for the external interrupt pin control.
`default_nettype none
module eipc_top_bench
   import eipc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [17:0] A1 = {IDX_CTL1, 2'b00};
   localparam logic [17:0] A2 = {IDX_CTL2, 2'b00};
   localparam logic [17:0] A3 = {IDX_CTL3, 2'b00};
   localparam logic [17:0] AS = {IDX_EVT_STATUS, 2'b00};
   localparam logic [17:0] AM = {IDX_EVT_MASK, 2'b00};
   localparam logic [17:0] AC = {IDX_CONFIG, 2'b00};
   localparam logic [17:0] AX = 18'h1c1c8;
   logic        clock = 1'b0;
   logic        rst, psel, penable, pwrite, pready, pslverr;
   logic        nmi_req, nmi_ack, irq, ack_en, e;
   logic [3:0]  pstrb, ack_dly;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [2:0]  lvl, pin_in, pin_out, pin_oe, int_req, int_req_low_pri, int_ack;
   logic [7:0]  acks;
   int          num_errors, checked, base;
   eipc_top u_eipc_top (
      .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .pin_in, .pin_out, .pin_oe, .int_req, .int_req_low_pri, .int_ack, .nmi_req, .nmi_ack, .irq
   );
   eipc_pins_model u_eipc_pins_model (
      .clock, .rst, .lvl, .ack_en, .ack_dly, .pin_out, .pin_oe, .int_req, .nmi_req,
      .pin_in, .int_ack, .nmi_ack, .acks
   );
   always #10 clock = ~clock;
   task automatic complete_run;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
      if (n == 16) begin
         chk(32'h1, 32'h0, "no pready");
         complete_run();
      end
   endtask : apb
   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [17:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(q, exp, what);
   endtask : rdc
   task automatic pins(input logic [2:0] v);
      @(posedge clock);
      lvl <= v;
      // Synchroniser and edge stage need three clocks; six leave margin.
      repeat (6) @(posedge clock);
      #1;
   endtask : pins
   task automatic t_reset;
      rdc(A1, 32'h40, "ctl1 reset");
      rdc(A2, 32'h40, "ctl2 reset");
      rdc(A3, 32'h40, "ctl3 reset");
      rdc(AS, 32'h0, "status reset");
      rdc(AC, 32'h0, "config reset");
      wr(AX, 32'hffff);
      chk({31'h0, e}, 32'h1, "unmapped write");
      rdc(AX, 32'h0, "unmapped read");
      chk({pin_oe, int_req, nmi_req, irq}, 32'h0, "reset outputs");
      $display("t_reset done");
   endtask : t_reset
   task automatic t_ctl;
      wr(A1, 32'hffff);
      rdc(A1, 32'h47, "ctl1 ones");
      wr(A2, 32'hffff);
      rdc(A2, 32'h5f, "ctl2 ones");
      chk(int_req_low_pri, 32'h3, "low priority");
      chk(pin_oe, 32'h0, "enabled pin undriven");
      wr(A1, 32'h0);
      wr(A2, 32'h10);
      pins(3'h7);
      rdc(A2, 32'h8010, "drive low");
      chk({pin_oe, pin_out}, 32'h10, "pin two low");
      wr(A2, 32'h8018);
      pins(3'h7);
      rdc(A2, 32'h58, "rise ignored");
      chk({pin_oe, pin_out}, 32'h12, "pin two high");
      wr(A2, 32'h19);
      chk(pin_oe, 32'h0, "enable frees pin");
      wr(A2, 32'h0);
      $display("t_ctl done");
   endtask : t_ctl
   task automatic t_poll;
      pins(3'h3);
      rdc(A3, 32'h8000, "flag when off");
      chk(int_req, 32'h0, "no request off");
      wr(A3, 32'h8004);
      pins(3'h7);
      rdc(A3, 32'h8044, "rising flag");
      wr(A3, 32'h8000);
      rdc(A3, 32'h40, "flag cleared");
      $display("t_poll done");
   endtask : t_poll
   task automatic t_edges;
      @(posedge clock);
      ack_en  <= 1'b1;
      ack_dly <= 4'h2;
      wr(A3, 32'h3);
      chk(int_req_low_pri, 32'h4, "pin three low");
      base = acks;
      pins(3'h3);
      pins(3'h7);
      pins(3'h3);
      pins(3'h7);
      chk(acks - base, 32'h2, "two requests");
      rdc(A3, 32'h8043, "flag kept");
      $display("t_edges done");
   endtask : t_edges
   task automatic t_withdraw;
      @(posedge clock);
      ack_en <= 1'b0;
      pins(3'h3);
      chk(int_req, 32'h4, "pending");
      wr(A3, 32'h8000);
      wr(A3, 32'h1);
      chk(int_req, 32'h0, "withdrawn");
      pins(3'h7);
      wr(A3, 32'h0);
      $display("t_withdraw done");
   endtask : t_withdraw
   task automatic t_irq;
      wr(AM, 32'h4);
      chk(irq, 32'h1, "irq raised");
      rdc(AS, 32'h6, "sticky events");
      wr(AM, 32'h1);
      chk(irq, 32'h0, "irq masked");
      wr(AS, 32'h6);
      wr(AM, 32'h7);
      rdc(AM, 32'h7, "mask");
      chk(irq, 32'h0, "irq cleared");
      rdc(AS, 32'h0, "events cleared");
      $display("t_irq done");
   endtask : t_irq
   task automatic t_nmi;
      wr(AC, 32'h1);
      wr(A1, 32'h3);
      chk(int_req_low_pri, 32'h0, "priority ignored");
      pins(3'h6);
      chk({int_req, nmi_req}, 32'h1, "edge to nmi");
      @(posedge clock);
      ack_en  <= 1'b1;
      ack_dly <= 4'h0;
      pins(3'h7);
      chk(nmi_req, 32'h0, "nmi taken");
      rdc(A1, 32'h8043, "pin one flag");
      $display("t_nmi done");
   endtask : t_nmi
   initial begin
      rst     = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 18'h0;
      pwdata  = 32'h0;
      pstrb   = 4'hf;
      lvl     = 3'h7;
      ack_en  = 1'b0;
      ack_dly = 4'h0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      // Let the pin synchroniser fill so the level bits read the real pins.
      repeat (3) @(posedge clock);
      t_reset();
      t_ctl();
      t_poll();
      t_edges();
      t_withdraw();
      t_irq();
      t_nmi();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clock);
      chk(32'h1, 32'h0, "timeout");
      complete_run();
   end
endmodule : eipc_top_bench
`default_nettype wire
